// ==== include/opmode_pkg.sv ====
// package: register map, field layout and power-state encodings of the operating-mode block
package opmode_pkg;
	// ------------------------------------------------------------
	// register offsets (lower 16 bits of the address)
	// ------------------------------------------------------------
	localparam logic [15:0] MODE_PIN_STATUS_ADDR = 16'hfff1;
	localparam logic [15:0] SYSTEM_CONTROL_ADDR = 16'hfff2;
	// own registers for the bus-controller and port inputs, and the power status
	localparam logic [15:0] AREA_WIDTH_CONTROL_ADDR = 16'hfff3;
	localparam logic [15:0] BUS_RELEASE_CONTROL_ADDR = 16'hfff4;
	localparam logic [15:0] PORT1_DIRECTION_ADDR = 16'hfff5;
	localparam logic [15:0] PORT2_DIRECTION_ADDR = 16'hfff6;
	localparam logic [15:0] PORT5_DIRECTION_ADDR = 16'hfff7;
	localparam logic [15:0] POWER_STATUS_ADDR = 16'hfff8;

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_STATUS_FIXED = 8'hc0;
	localparam int STANDBY_ON_SLEEP_BIT = 7;
	localparam int STANDBY_WAIT_MSB = 6;
	localparam int STANDBY_WAIT_LSB = 4;
	localparam int USER_FLAG_ENABLE_BIT = 3;
	localparam int NONMASKABLE_EDGE_BIT = 2;
	localparam int SYSTEM_CONTROL_FIXED_ONE_BIT = 1;
	localparam int ONCHIP_RAM_ENABLE_BIT = 0;
	localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h0b;
	localparam logic [7:0] AREA_WIDTH_RESET_8BIT = 8'hff;
	localparam logic [7:0] AREA_WIDTH_RESET_16BIT = 8'h00;
	localparam logic [7:0] BUS_RELEASE_RESET = 8'he0;
	localparam logic [7:0] PORT_DIRECTION_RESET = 8'h00;

	// ------------------------------------------------------------
	// address space sizes, as address width in bits
	// ------------------------------------------------------------
	localparam logic [4:0] SPACE_64K_BITS = 5'h10;
	localparam logic [4:0] SPACE_1M_BITS = 5'h14;
	localparam logic [4:0] SPACE_16M_BITS = 5'h18;

	// ------------------------------------------------------------
	// standby oscillator settling wait, in states
	// ------------------------------------------------------------
	localparam logic [17:0] WAIT_8K = 18'h02000;
	localparam logic [17:0] WAIT_16K = 18'h04000;
	localparam logic [17:0] WAIT_32K = 18'h08000;
	localparam logic [17:0] WAIT_64K = 18'h10000;
	localparam logic [17:0] WAIT_128K = 18'h20000;

	// ------------------------------------------------------------
	// power states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		PWR_RUN = 4'h1,
		PWR_SLEEP = 4'h2,
		PWR_STANDBY = 4'h4,
		PWR_SETTLE = 4'h8
	} power_state_t;
endpackage : opmode_pkg

// ==== hdl/opmode_regfile.sv ====
// little register file holding the bus-controller and port direction bytes
`timescale 1ns/10ps
module opmode_regfile (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] mode_i,
	input wire logic wr_i,
	input wire logic [2:0] wr_idx_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [2:0] rd_idx_i,
	output logic [7:0] rd_data_o,
	output logic [7:0] area_width_o,
	output logic [7:0] bus_release_o,
	output logic [7:0] port1_dir_o,
	output logic [7:0] port2_dir_o,
	output logic [3:0] port5_dir_o
);
	logic [7:0] mem_q [0:3];
	logic init_q;

	// ------------------------------------------------------------
	// storage; area widths take their mode default one cycle after reset
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_q[0] <= opmode_pkg::AREA_WIDTH_RESET_8BIT;
			mem_q[1] <= opmode_pkg::BUS_RELEASE_RESET;
			mem_q[2] <= opmode_pkg::PORT_DIRECTION_RESET;
			mem_q[3] <= opmode_pkg::PORT_DIRECTION_RESET;
			init_q <= 1'b1;
		end else begin
			init_q <= 1'b0;
			if (init_q) begin
				// modes 2 and 4 start with every area at 16 bits
				if (mode_i == 3'h2 || mode_i == 3'h4) begin
					mem_q[0] <= opmode_pkg::AREA_WIDTH_RESET_16BIT;
				end
			end else if (wr_i && wr_idx_i < 3'h4) begin
				mem_q[wr_idx_i[1:0]] <= wr_data_i;
			end
		end
	end

	logic [3:0] p5_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			p5_q <= 4'h0;
		end else if (wr_i && wr_idx_i == 3'h4) begin
			p5_q <= wr_data_i[3:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_idx_i < 3'h4) begin
			rd_data_o <= mem_q[rd_idx_i[1:0]];
		end else begin
			rd_data_o <= {4'h0, p5_q};
		end
	end

	assign area_width_o = mem_q[0];
	assign bus_release_o = mem_q[1];
	assign port1_dir_o = mem_q[2];
	assign port2_dir_o = mem_q[3];
	assign port5_dir_o = p5_q;
endmodule : opmode_regfile

// ==== hdl/opmode_ctrl.sv ====
// operating-mode decode, mode status and system control registers
//
// Overview of operation
// - decode mode pins into modes one to seven
// - modes 1-4: no ROM, 1M or 16M
// - mode 5: ROM plus external, 1 Mbyte
// - modes 6/7 single-chip, 64K or 1M
// - modes 1,3,5 start 8-bit, any 16 widens
// - modes 2,4 start 16-bit, all 8 narrows
// - port 4 data low byte in 16-bit
// - mode 5 ports address only when direction set
// - modes 3/4: A20 always, A23-21 via release
// - ports 1,2,5 address in modes 1-4
// - mode status reads 11000 plus pins
// - mode pins latched when status is read
// - control bit 1 reads one, resets 0x0b
// - standby bit chooses sleep or standby
// - standby bit stays set after interrupt exit
// - wait field selects settling states count
// - user flag enable chooses mask or user
// - edge select chooses nonmaskable edge
// - RAM enable; off routes RAM external
// - RAM enable reset only, kept in standby
// - exception entry sets mask, maybe user bit
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module opmode_ctrl (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic [2:0] MODE_SELECT_PINS_I,
	input wire logic [15:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic SLEEP_EXEC_I,
	input wire logic WAKE_INTERRUPT_I,
	input wire logic EXCEPTION_ENTRY_I,
	input wire logic NMI_PIN_I,
	output logic NMI_REQUEST_O,
	output logic SET_MASK_BIT_O,
	output logic SET_USER_BIT_O,
	output logic USER_BIT_IS_MASK_O,
	output logic [3:0] POWER_STATE_O,
	output logic CLOCK_RUN_O,
	output logic [2:0] MODE_O,
	output logic EXPANDED_O,
	output logic ONCHIP_ROM_EN_O,
	output logic ONCHIP_RAM_EN_O,
	output logic ADVANCED_CPU_O,
	output logic [4:0] ADDR_SPACE_BITS_O,
	output logic BUS_16BIT_O,
	output logic PORT3_DATA_O,
	output logic PORT4_DATA_O,
	output logic [7:0] PORT1_ADDR_O,
	output logic [7:0] PORT2_ADDR_O,
	output logic [3:0] PORT5_ADDR_O,
	output logic [3:0] PORTA_ADDR_O
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic is_mode(input logic [2:0] m,
		input logic [2:0] lo, input logic [2:0] hi);
		is_mode = (m >= lo) && (m <= hi);
	endfunction : is_mode

	function automatic logic [17:0] wait_states(input logic [2:0] sel);
		case (sel)
			3'h0: wait_states = opmode_pkg::WAIT_8K;
			3'h1: wait_states = opmode_pkg::WAIT_16K;
			3'h2: wait_states = opmode_pkg::WAIT_32K;
			3'h3: wait_states = opmode_pkg::WAIT_64K;
			// 11x is illegal; treated as the longest wait to stay safe
			default: wait_states = opmode_pkg::WAIT_128K;
		endcase
	endfunction : wait_states

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	// pins are strapped and held steady by the board
	logic [2:0] mode;
	assign mode = MODE_SELECT_PINS_I;
	logic mode_1_4;
	logic mode_1_5;
	logic narrow_start;
	assign mode_1_4 = is_mode(mode, 3'h1, 3'h4);
	assign mode_1_5 = is_mode(mode, 3'h1, 3'h5);
	assign narrow_start = mode[0] && mode_1_5;

	// ------------------------------------------------------------
	// register bus decode
	// ------------------------------------------------------------
	logic hit_status;
	logic hit_sysctl;
	logic hit_power;
	logic [2:0] file_idx;
	logic file_hit;
	always_comb begin
		hit_status = 1'b0;
		hit_sysctl = 1'b0;
		hit_power = 1'b0;
		file_hit = 1'b0;
		file_idx = 3'h0;
		if (ADDR_I == opmode_pkg::MODE_PIN_STATUS_ADDR) begin
			hit_status = 1'b1;
		end else if (ADDR_I == opmode_pkg::SYSTEM_CONTROL_ADDR) begin
			hit_sysctl = 1'b1;
		end else if (ADDR_I == opmode_pkg::POWER_STATUS_ADDR) begin
			hit_power = 1'b1;
		end else if (ADDR_I >= opmode_pkg::AREA_WIDTH_CONTROL_ADDR &&
			ADDR_I <= opmode_pkg::PORT5_DIRECTION_ADDR) begin
			file_hit = 1'b1;
			file_idx = 3'(ADDR_I - opmode_pkg::AREA_WIDTH_CONTROL_ADDR);
		end
	end

	// ------------------------------------------------------------
	// mode status: pins latched on read
	// ------------------------------------------------------------
	logic [2:0] mode_latch_q;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mode_latch_q <= 3'h0;
		end else if (RD_I && hit_status) begin
			mode_latch_q <= MODE_SELECT_PINS_I;
		end
	end
	// writes to this register are never decoded

	// ------------------------------------------------------------
	// system control register
	// ------------------------------------------------------------
	logic standby_on_sleep_q;
	logic [2:0] standby_wait_select_q;
	logic user_flag_enable_q;
	logic nonmaskable_edge_select_q;
	logic onchip_ram_enable_q;
	logic sysctl_wr;
	assign sysctl_wr = WR_I && hit_sysctl;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			standby_on_sleep_q <= opmode_pkg::SYSTEM_CONTROL_RESET[7];
			standby_wait_select_q <= opmode_pkg::SYSTEM_CONTROL_RESET[6:4];
			user_flag_enable_q <= opmode_pkg::SYSTEM_CONTROL_RESET[3];
			nonmaskable_edge_select_q <= opmode_pkg::SYSTEM_CONTROL_RESET[2];
		end else if (sysctl_wr) begin
			// only a write or a reset clears the standby bit
			standby_on_sleep_q <= WDATA_I[opmode_pkg::STANDBY_ON_SLEEP_BIT];
			standby_wait_select_q <= WDATA_I[opmode_pkg::STANDBY_WAIT_MSB:
				opmode_pkg::STANDBY_WAIT_LSB];
			user_flag_enable_q <= WDATA_I[opmode_pkg::USER_FLAG_ENABLE_BIT];
			nonmaskable_edge_select_q <=
				WDATA_I[opmode_pkg::NONMASKABLE_EDGE_BIT];
		end
	end

	// only the reset pin initialises this bit; standby leaves it alone
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			onchip_ram_enable_q <= opmode_pkg::SYSTEM_CONTROL_RESET[0];
		end else if (sysctl_wr) begin
			onchip_ram_enable_q <= WDATA_I[opmode_pkg::ONCHIP_RAM_ENABLE_BIT];
		end
	end

	logic [7:0] sysctl_value;
	always_comb begin
		sysctl_value = 8'h00;
		sysctl_value[opmode_pkg::STANDBY_ON_SLEEP_BIT] = standby_on_sleep_q;
		sysctl_value[opmode_pkg::STANDBY_WAIT_MSB:
			opmode_pkg::STANDBY_WAIT_LSB] = standby_wait_select_q;
		sysctl_value[opmode_pkg::USER_FLAG_ENABLE_BIT] = user_flag_enable_q;
		sysctl_value[opmode_pkg::NONMASKABLE_EDGE_BIT] =
			nonmaskable_edge_select_q;
		sysctl_value[opmode_pkg::SYSTEM_CONTROL_FIXED_ONE_BIT] = 1'b1;
		sysctl_value[opmode_pkg::ONCHIP_RAM_ENABLE_BIT] = onchip_ram_enable_q;
	end

	// ------------------------------------------------------------
	// power-down sequencing
	// ------------------------------------------------------------
	opmode_pkg::power_state_t pstate_q;
	logic [17:0] settle_cnt_q;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pstate_q <= opmode_pkg::PWR_RUN;
			settle_cnt_q <= 18'h00000;
		end else begin
			case (pstate_q)
				opmode_pkg::PWR_RUN: begin
					if (SLEEP_EXEC_I) begin
						pstate_q <= standby_on_sleep_q ?
							opmode_pkg::PWR_STANDBY : opmode_pkg::PWR_SLEEP;
					end
				end
				opmode_pkg::PWR_SLEEP: begin
					if (WAKE_INTERRUPT_I) begin
						pstate_q <= opmode_pkg::PWR_RUN;
					end
				end
				opmode_pkg::PWR_STANDBY: begin
					if (WAKE_INTERRUPT_I) begin
						pstate_q <= opmode_pkg::PWR_SETTLE;
						settle_cnt_q <= wait_states(standby_wait_select_q) -
							18'h00001;
					end
				end
				opmode_pkg::PWR_SETTLE: begin
					// software must pick a long enough wait
					if (settle_cnt_q == 18'h00000) begin
						pstate_q <= opmode_pkg::PWR_RUN;
					end else begin
						settle_cnt_q <= settle_cnt_q - 18'h00001;
					end
				end
				default: pstate_q <= opmode_pkg::PWR_RUN;
			endcase
		end
	end
	assign POWER_STATE_O = pstate_q;
	assign CLOCK_RUN_O = (pstate_q != opmode_pkg::PWR_STANDBY) &&
		(pstate_q != opmode_pkg::PWR_SETTLE);

	// ------------------------------------------------------------
	// register file for bus width, release and port directions
	// ------------------------------------------------------------
	logic [7:0] file_rdata;
	logic [7:0] area_width;
	logic [7:0] bus_release;
	logic [7:0] port1_dir;
	logic [7:0] port2_dir;
	logic [3:0] port5_dir;
	opmode_regfile u_regfile (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.mode_i(mode),
		.wr_i(WR_I && file_hit),
		.wr_idx_i(file_idx),
		.wr_data_i(WDATA_I),
		.rd_idx_i(file_idx),
		.rd_data_o(file_rdata),
		.area_width_o(area_width),
		.bus_release_o(bus_release),
		.port1_dir_o(port1_dir),
		.port2_dir_o(port2_dir),
		.port5_dir_o(port5_dir)
	);

	// ------------------------------------------------------------
	// read data, one cycle after the strobe
	// ------------------------------------------------------------
	logic rd_status_q;
	logic rd_sysctl_q;
	logic rd_power_q;
	logic rd_file_q;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rd_status_q <= 1'b0;
			rd_sysctl_q <= 1'b0;
			rd_power_q <= 1'b0;
			rd_file_q <= 1'b0;
		end else begin
			rd_status_q <= RD_I && hit_status;
			rd_sysctl_q <= RD_I && hit_sysctl;
			rd_power_q <= RD_I && hit_power;
			rd_file_q <= RD_I && file_hit;
		end
	end

	logic [7:0] power_value_q;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			power_value_q <= 8'h00;
		end else begin
			power_value_q <= {4'h0, pstate_q};
		end
	end

	logic [7:0] sysctl_rd_q;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sysctl_rd_q <= 8'h00;
		end else begin
			sysctl_rd_q <= sysctl_value;
		end
	end

	always_comb begin
		RDATA_O = 8'h00;
		if (rd_status_q) begin
			RDATA_O = opmode_pkg::MODE_STATUS_FIXED | {5'h00, mode_latch_q};
		end else if (rd_sysctl_q) begin
			RDATA_O = sysctl_rd_q;
		end else if (rd_power_q) begin
			RDATA_O = power_value_q;
		end else if (rd_file_q) begin
			RDATA_O = file_rdata;
		end
	end

	// ------------------------------------------------------------
	// interrupt-related controls
	// ------------------------------------------------------------
	logic nmi_prev_q;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			nmi_prev_q <= 1'b1;
			NMI_REQUEST_O <= 1'b0;
		end else begin
			nmi_prev_q <= NMI_PIN_I;
			NMI_REQUEST_O <= nonmaskable_edge_select_q ?
				(NMI_PIN_I && !nmi_prev_q) :
				(!NMI_PIN_I && nmi_prev_q);
		end
	end

	assign USER_BIT_IS_MASK_O = !user_flag_enable_q;
	assign SET_MASK_BIT_O = EXCEPTION_ENTRY_I;
	assign SET_USER_BIT_O = EXCEPTION_ENTRY_I && !user_flag_enable_q;

	// ------------------------------------------------------------
	// mode-dependent memory and pin functions
	// ------------------------------------------------------------
	// pattern 000 falls through every decode; nothing defined
	assign MODE_O = mode;
	assign EXPANDED_O = mode_1_5;
	assign ONCHIP_ROM_EN_O = !mode_1_4 && mode != 3'h0;
	assign ONCHIP_RAM_EN_O = onchip_ram_enable_q;
	assign ADVANCED_CPU_O = mode != 3'h6;

	always_comb begin
		ADDR_SPACE_BITS_O = opmode_pkg::SPACE_1M_BITS;
		if (mode == 3'h3 || mode == 3'h4) begin
			ADDR_SPACE_BITS_O = opmode_pkg::SPACE_16M_BITS;
		end else if (mode == 3'h6) begin
			ADDR_SPACE_BITS_O = opmode_pkg::SPACE_64K_BITS;
		end
	end

	always_comb begin
		BUS_16BIT_O = 1'b0;
		if (mode_1_5) begin
			if (narrow_start) begin
				BUS_16BIT_O = area_width != 8'hff;
			end else begin
				BUS_16BIT_O = area_width != 8'hff;
			end
		end
	end

	assign PORT3_DATA_O = mode_1_5;
	assign PORT4_DATA_O = mode_1_5 && BUS_16BIT_O;

	always_comb begin
		PORT1_ADDR_O = 8'h00;
		PORT2_ADDR_O = 8'h00;
		PORT5_ADDR_O = 4'h0;
		if (mode_1_4) begin
			PORT1_ADDR_O = 8'hff;
			PORT2_ADDR_O = 8'hff;
			PORT5_ADDR_O = 4'hf;
		end else if (mode == 3'h5) begin
			PORT1_ADDR_O = port1_dir;
			PORT2_ADDR_O = port2_dir;
			PORT5_ADDR_O = port5_dir;
		end
	end

	always_comb begin
		PORTA_ADDR_O = 4'h0;
		if (mode == 3'h3 || mode == 3'h4) begin
			PORTA_ADDR_O = {~bus_release[7:5], 1'b1};
		end
	end
endmodule : opmode_ctrl

// ==== sim/opmode_ctrl_sva.sv ====
// checker: port-level assertions for the operating-mode block
`timescale 1ns/10ps
module opmode_ctrl_sva (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic [2:0] MODE_SELECT_PINS_I,
	input wire logic [15:0] ADDR_I,
	input wire logic RD_I,
	input wire logic SLEEP_EXEC_I,
	input wire logic EXCEPTION_ENTRY_I,
	input wire logic NMI_PIN_I,
	input wire logic [7:0] RDATA_O,
	input wire logic NMI_REQUEST_O,
	input wire logic SET_MASK_BIT_O,
	input wire logic SET_USER_BIT_O,
	input wire logic USER_BIT_IS_MASK_O,
	input wire logic [3:0] POWER_STATE_O,
	input wire logic CLOCK_RUN_O,
	input wire logic EXPANDED_O,
	input wire logic ONCHIP_ROM_EN_O,
	input wire logic ONCHIP_RAM_EN_O,
	input wire logic [4:0] ADDR_SPACE_BITS_O,
	input wire logic BUS_16BIT_O,
	input wire logic PORT4_DATA_O,
	input wire logic [7:0] PORT1_ADDR_O,
	input wire logic [3:0] PORTA_ADDR_O
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	logic [2:0] m;
	logic [4:0] nmi_hist_q;
	assign m = MODE_SELECT_PINS_I;
	// the request may trail the pin change by a few samples
	always_ff @(posedge CORE_CLK_I) begin
		nmi_hist_q <= {nmi_hist_q[3:0], NMI_PIN_I};
	end
	sequence status_rd;
		RD_I && ADDR_I == opmode_pkg::MODE_PIN_STATUS_ADDR;
	endsequence
	sequence ctrl_rd;
		RD_I && ADDR_I == opmode_pkg::SYSTEM_CONTROL_ADDR;
	endsequence
	sequence sleep_req;
		POWER_STATE_O == opmode_pkg::PWR_RUN && SLEEP_EXEC_I;
	endsequence
	sequence settle_start;
		$rose(POWER_STATE_O == opmode_pkg::PWR_SETTLE);
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_mode_decode: assert property (EXPANDED_O == (m inside {[1:5]}))
		else $error("expanded flag does not match mode pins");
	chk_rom_enable: assert property (ONCHIP_ROM_EN_O == (m >= 3'h5))
		else $error("rom enable does not match mode pins");
	chk_space_size: assert property (m != 3'h0 |-> ADDR_SPACE_BITS_O ==
		(m == 3'h6 ? 5'h10 : (m inside {3, 4}) ? 5'h18 : 5'h14))
		else $error("address space size wrong for mode");
	chk_port4_data: assert property (PORT4_DATA_O == (EXPANDED_O && BUS_16BIT_O))
		else $error("port 4 data role wrong");
	chk_addr_ports: assert property (m inside {[1:4]} |-> PORT1_ADDR_O == 8'hff)
		else $error("port 1 not all address in modes 1 to 4");
	chk_porta_a20: assert property (PORTA_ADDR_O[0] == (m inside {3, 4}))
		else $error("address bit 20 role wrong");
	chk_status_read: assert property (status_rd |=>
		RDATA_O == {5'h18, $past(m)})
		else $error("mode status read wrong");
	chk_control_read: assert property (ctrl_rd |=>
		RDATA_O[1] && RDATA_O[0] == ONCHIP_RAM_EN_O)
		else $error("system control fixed or ram bit wrong");
	chk_sleep_entry: assert property (sleep_req |=> POWER_STATE_O inside
		{opmode_pkg::PWR_SLEEP, opmode_pkg::PWR_STANDBY})
		else $error("sleep request did not leave run");
	chk_clock_stop: assert property (CLOCK_RUN_O == !(POWER_STATE_O inside
		{opmode_pkg::PWR_STANDBY, opmode_pkg::PWR_SETTLE}))
		else $error("clock run flag wrong for power state");
	chk_settle_hold: assert property (settle_start |->
		(POWER_STATE_O == opmode_pkg::PWR_SETTLE) [*8])
		else $error("settle wait cut short");
	chk_user_mask: assert property (SET_MASK_BIT_O == EXCEPTION_ENTRY_I &&
		SET_USER_BIT_O == (EXCEPTION_ENTRY_I && USER_BIT_IS_MASK_O))
		else $error("exception entry mask bits wrong");
	chk_nmi_cause: assert property (NMI_REQUEST_O |->
		nmi_hist_q != 5'h00 && nmi_hist_q != 5'h1f)
		else $error("nonmaskable request without pin edge");
endmodule : opmode_ctrl_sva

// ==== sim/mode_strap_model.sv ====
// board strapping model for the mode select pins
`timescale 1ns/10ps
module mode_strap_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] pattern_i,
	output logic [2:0] pins_o
);
	logic [2:0] pins_q = 3'h1;
	// pins only move while reset is held and never take 000
	always_ff @(posedge clk_i) begin
		if (rst_i && pattern_i != 3'h0) begin
			pins_q <= pattern_i;
		end
	end
	assign pins_o = pins_q;
endmodule : mode_strap_model

// ==== sim/tb_opmode_ctrl.sv ====
// testbench for the operating-mode and system control block
`timescale 1ns/10ps
module tb_opmode_ctrl;
	localparam logic [15:0] A_ST = opmode_pkg::MODE_PIN_STATUS_ADDR;
	localparam logic [15:0] A_SC = opmode_pkg::SYSTEM_CONTROL_ADDR;
	logic CORE_CLK_I, RST_I, WR_I, RD_I, SLEEP_EXEC_I, WAKE_INTERRUPT_I;
	logic EXCEPTION_ENTRY_I, NMI_PIN_I, NMI_REQUEST_O, SET_MASK_BIT_O;
	logic SET_USER_BIT_O, USER_BIT_IS_MASK_O, CLOCK_RUN_O, EXPANDED_O;
	logic ONCHIP_ROM_EN_O, ONCHIP_RAM_EN_O, ADVANCED_CPU_O, BUS_16BIT_O;
	logic PORT3_DATA_O, PORT4_DATA_O, rd_seen;
	logic [2:0] MODE_SELECT_PINS_I, MODE_O, pat;
	logic [15:0] ADDR_I;
	logic [7:0] WDATA_I, RDATA_O, PORT1_ADDR_O, PORT2_ADDR_O, r;
	logic [3:0] POWER_STATE_O, PORT5_ADDR_O, PORTA_ADDR_O;
	logic [4:0] ADDR_SPACE_BITS_O;
	logic [7:0] exp_q[$];
	int err_count, num_checks, n;

	mode_strap_model i_mode_strap_model (.clk_i(CORE_CLK_I), .rst_i(RST_I),
		.pattern_i(pat), .pins_o(MODE_SELECT_PINS_I));
	opmode_ctrl i_opmode_ctrl (.CORE_CLK_I, .RST_I, .MODE_SELECT_PINS_I,
		.ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .SLEEP_EXEC_I,
		.WAKE_INTERRUPT_I, .EXCEPTION_ENTRY_I, .NMI_PIN_I, .NMI_REQUEST_O,
		.SET_MASK_BIT_O, .SET_USER_BIT_O, .USER_BIT_IS_MASK_O,
		.POWER_STATE_O, .CLOCK_RUN_O, .MODE_O, .EXPANDED_O,
		.ONCHIP_ROM_EN_O, .ONCHIP_RAM_EN_O, .ADVANCED_CPU_O,
		.ADDR_SPACE_BITS_O, .BUS_16BIT_O, .PORT3_DATA_O, .PORT4_DATA_O,
		.PORT1_ADDR_O, .PORT2_ADDR_O, .PORT5_ADDR_O, .PORTA_ADDR_O);

	// ------------------------------------------------------------
	// clock, compare and bus tasks
	// ------------------------------------------------------------
	initial begin
		CORE_CLK_I = 1'b0;
		forever #20 CORE_CLK_I = ~CORE_CLK_I;
	end
	task automatic print_verdict();
		if (err_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic check_val(input string name, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask : check_val
	// read data stand only in the cycle after the strobe
	initial rd_seen = 1'b0;
	always @(negedge CORE_CLK_I) begin
		if (rd_seen) check_val("rdata", exp_q.pop_front(), RDATA_O);
		rd_seen = RD_I;
	end
	task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CORE_CLK_I);
		WR_I <= 1'b1;
		ADDR_I <= a;
		WDATA_I <= d;
		@(posedge CORE_CLK_I);
		WR_I <= 1'b0;
		@(negedge CORE_CLK_I);
	endtask : bus_wr
	task automatic bus_rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge CORE_CLK_I);
		RD_I <= 1'b1;
		ADDR_I <= a;
		exp_q.push_back(e);
		@(posedge CORE_CLK_I);
		RD_I <= 1'b0;
		@(negedge CORE_CLK_I);
	endtask : bus_rd
	task automatic do_reset(input logic [2:0] m);
		@(posedge CORE_CLK_I);
		RST_I <= 1'b1;
		pat <= m;
		repeat (5) @(posedge CORE_CLK_I);
		RST_I <= 1'b0;
		repeat (2) @(posedge CORE_CLK_I);
	endtask : do_reset
	task automatic wait_pwr(input logic [3:0] s, input int lim);
		n = 0;
		while (POWER_STATE_O !== s) begin
			@(negedge CORE_CLK_I);
			n++;
			if (n > lim) begin
				err_count++;
				print_verdict();
			end
		end
	endtask : wait_pwr
	task automatic nmi_try(input logic v, input logic [7:0] e);
		int c;
		c = 0;
		@(posedge CORE_CLK_I);
		NMI_PIN_I <= v;
		repeat (5) begin
			@(negedge CORE_CLK_I);
			if (NMI_REQUEST_O === 1'b1) c++;
		end
		check_val("nmi_request", e, c[7:0]);
	endtask : nmi_try

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		RST_I = 1'b1;
		pat = 3'h1;
		{WR_I, RD_I, SLEEP_EXEC_I, WAKE_INTERRUPT_I, EXCEPTION_ENTRY_I} = '0;
		NMI_PIN_I = 1'b1;
		ADDR_I = 16'h0000;
		WDATA_I = 8'h00;
		err_count = 0;
		num_checks = 0;
		void'($urandom(42922));
		for (int m = 1; m < 8; m++) begin
			do_reset(m[2:0]);
			bus_rd(A_ST, {5'h18, m[2:0]});
			bus_rd(A_SC, opmode_pkg::SYSTEM_CONTROL_RESET);
			check_val("mode", m[7:0], MODE_O);
			check_val("rom", m >= 5, ONCHIP_ROM_EN_O);
			check_val("expanded", m <= 5, EXPANDED_O);
			check_val("space", m == 6 ? 8'h10 : (m inside {3, 4}) ? 8'h18 : 8'h14,
				ADDR_SPACE_BITS_O);
			check_val("advanced", m != 6, ADVANCED_CPU_O);
			check_val("bus16", m == 2 || m == 4, BUS_16BIT_O);
			check_val("port3", m <= 5, PORT3_DATA_O);
			check_val("port1", m <= 4 ? 8'hff : 8'h00, PORT1_ADDR_O);
			check_val("port2", m <= 4 ? 8'hff : 8'h00, PORT2_ADDR_O);
			check_val("port5", m <= 4 ? 8'h0f : 8'h00, PORT5_ADDR_O);
			check_val("porta", (m inside {3, 4}) ? 8'h01 : 8'h00, PORTA_ADDR_O);
			if (m <= 5) begin
				// odd modes widen on one 16-bit area, even narrow on all 8-bit
				bus_wr(opmode_pkg::AREA_WIDTH_CONTROL_ADDR, m[0] ? 8'hfe : 8'hff);
				check_val("bus16", m[0], BUS_16BIT_O);
				check_val("port4", m[0], PORT4_DATA_O);
			end
			if (m == 5) begin
				bus_wr(opmode_pkg::PORT1_DIRECTION_ADDR, 8'ha5);
				bus_wr(opmode_pkg::PORT5_DIRECTION_ADDR, 8'h09);
				bus_wr(opmode_pkg::PORT2_DIRECTION_ADDR, 8'h3c);
				check_val("port1", 8'ha5, PORT1_ADDR_O);
				check_val("port2", 8'h3c, PORT2_ADDR_O);
				check_val("port5", 8'h09, PORT5_ADDR_O);
			end
			if (m inside {3, 4}) begin
				bus_wr(opmode_pkg::BUS_RELEASE_CONTROL_ADDR, 8'h00);
				check_val("porta", 8'h0f, PORTA_ADDR_O);
			end
		end
		bus_wr(A_ST, 8'h00);
		bus_rd(A_ST, 8'hc7);
		bus_rd(16'h0100, 8'h00);
		r = $urandom;
		bus_wr(A_SC, r);
		bus_rd(A_SC, r | 8'h02);
		bus_wr(A_SC, 8'h0b);
		@(posedge CORE_CLK_I);
		SLEEP_EXEC_I <= 1'b1;
		@(posedge CORE_CLK_I);
		SLEEP_EXEC_I <= 1'b0;
		@(negedge CORE_CLK_I);
		check_val("power", 8'h02, POWER_STATE_O);
		@(posedge CORE_CLK_I);
		WAKE_INTERRUPT_I <= 1'b1;
		@(posedge CORE_CLK_I);
		WAKE_INTERRUPT_I <= 1'b0;
		wait_pwr(opmode_pkg::PWR_RUN, 10);
		// shortest wait keeps the run short; real boards need more
		bus_wr(A_SC, 8'h82);
		@(posedge CORE_CLK_I);
		SLEEP_EXEC_I <= 1'b1;
		@(posedge CORE_CLK_I);
		SLEEP_EXEC_I <= 1'b0;
		@(negedge CORE_CLK_I);
		check_val("power", 8'h04, POWER_STATE_O);
		check_val("clock_run", 8'h00, CLOCK_RUN_O);
		@(posedge CORE_CLK_I);
		WAKE_INTERRUPT_I <= 1'b1;
		@(posedge CORE_CLK_I);
		WAKE_INTERRUPT_I <= 1'b0;
		wait_pwr(opmode_pkg::PWR_RUN, 9000);
		check_val("settle_ok", n >= 8190 && n <= 8195, 8'h01);
		bus_rd(A_SC, 8'h82);
		check_val("ram_en", 8'h00, ONCHIP_RAM_EN_O);
		bus_rd(opmode_pkg::POWER_STATUS_ADDR, {4'h0, opmode_pkg::PWR_RUN});
		for (int u = 0; u < 2; u++) begin
			bus_wr(A_SC, u ? 8'h0b : 8'h03);
			@(posedge CORE_CLK_I);
			EXCEPTION_ENTRY_I <= 1'b1;
			@(negedge CORE_CLK_I);
			check_val("set_mask", 8'h01, SET_MASK_BIT_O);
			check_val("set_user", u == 0, SET_USER_BIT_O);
			check_val("user_mask", u == 0, USER_BIT_IS_MASK_O);
			@(posedge CORE_CLK_I);
			EXCEPTION_ENTRY_I <= 1'b0;
		end
		nmi_try(1'b0, 8'h01);
		nmi_try(1'b1, 8'h00);
		bus_wr(A_SC, 8'h0f);
		nmi_try(1'b0, 8'h00);
		nmi_try(1'b1, 8'h01);
		repeat (2) @(posedge CORE_CLK_I);
		print_verdict();
	end
endmodule : tb_opmode_ctrl

bind opmode_ctrl opmode_ctrl_sva i_opmode_ctrl_sva (.CORE_CLK_I, .RST_I,
	.MODE_SELECT_PINS_I, .ADDR_I, .RD_I, .SLEEP_EXEC_I, .EXCEPTION_ENTRY_I,
	.NMI_PIN_I, .RDATA_O, .NMI_REQUEST_O, .SET_MASK_BIT_O, .SET_USER_BIT_O,
	.USER_BIT_IS_MASK_O, .POWER_STATE_O, .CLOCK_RUN_O, .EXPANDED_O,
	.ONCHIP_ROM_EN_O, .ONCHIP_RAM_EN_O, .ADDR_SPACE_BITS_O, .BUS_16BIT_O,
	.PORT4_DATA_O, .PORT1_ADDR_O, .PORTA_ADDR_O);
